// ==== pnp_pkg.sv ====
/*
  pnp_pkg: constants and carrier types for the nonvolatile settings
  program and verify logic.
  assumes: an 8-bit register access port fed by the serial target logic.
*/
`default_nettype none
package pnp_pkg;
  // ---------------------------------
  // register map
  // ---------------------------------
  localparam logic [7:0] PNP_ADDR_PIN_CONTROL = 8'h29;
  localparam logic [7:0] PNP_ADDR_NVM_CMD = 8'h34;
  localparam logic [7:0] PNP_PIN_CONTROL_RESET = 8'h00;
  // ---------------------------------
  // command codes and fields
  // ---------------------------------
  localparam logic [7:0] PNP_OFF_REQUEST = 8'h01;
  localparam logic [7:0] PNP_COMM_ENABLE_COMMAND = 8'h69;
  localparam logic [7:0] PNP_PROGRAM_COMMAND = 8'h0a;
  localparam logic [7:0] PNP_VERIFY_COMMAND = 8'h07;
  localparam int PNP_VERIFY_RESULT_BIT = 7;
  localparam int PNP_BUSY_BIT = 0;
  localparam int PNP_COMM_BIT = 1;
  // ---------------------------------
  // sizes
  // ---------------------------------
  localparam int PNP_NVM_WORDS = 16;
  localparam int PNP_IDX_W = 4;
  localparam logic [PNP_IDX_W-1:0] PNP_IDX_LAST = 4'hf;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pnp_req_t;

  typedef enum logic [2:0] {
    PNP_IDLE = 3'b001,
    PNP_PROG = 3'b010,
    PNP_VERIFY = 3'b100
  } pnp_state_t;
endpackage
`default_nettype wire

// ==== pnp_nvm_seq.sv ====
/*
  pnp_nvm_seq: off request, communication enable, program and verify
  of the nonvolatile default settings.
  assumes: host register writes arrive as one-cycle requests on clk_sys;
  current settings are presented as a packed byte vector; wake pin is
  asynchronous.
*/
// Behaviour
// - writing 0x01 to multifunction_pin_control at 0x29 is an off request that enters Initialize with rails off.
// - in Initialize, writing 0x69 to nvm_command enables communication so later accesses are taken.
// - writing 0x0a to nvm_command at 0x34 stores the current settings into the memory as defaults.
// - writing 0x07 to nvm_command reads the memory back and compares it with the current settings.
// - the pass or fail outcome of the compare is readable in bit 7 of nvm_command.
`timescale 1ns/1ns
`default_nettype none
module pnp_nvm_seq
  import pnp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire pnp_req_t req,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic [PNP_NVM_WORDS*8-1:0] settings,
  input wire logic wake_pin,
  output logic rails_on,
  output logic in_initialize,
  output logic comm_enabled,
  output logic busy,
  input wire logic [PNP_IDX_W-1:0] nvm_rd_idx,
  output logic [7:0] nvm_rd_data
);
  // ---------------------------------
  // storage and state
  // ---------------------------------
  logic [7:0] nvm [PNP_NVM_WORDS];
  pnp_state_t state;
  pnp_state_t next_state;
  logic [PNP_IDX_W-1:0] idx;
  logic [7:0] pin_control;
  logic verify_pass;
  logic mismatch;
  logic [2:0] wake_sync;

  // ---------------------------------
  // decode
  // ---------------------------------
  wire accept = ~in_initialize | comm_enabled;
  wire hit_pin = req.wr & (req.addr == PNP_ADDR_PIN_CONTROL) & accept;
  wire hit_cmd = req.wr & (req.addr == PNP_ADDR_NVM_CMD);
  wire cmd_ok = hit_cmd & accept & (state == PNP_IDLE);
  wire off_req = hit_pin & (req.wdata == PNP_OFF_REQUEST);
  wire comm_cmd = hit_cmd & in_initialize & (req.wdata == PNP_COMM_ENABLE_COMMAND);
  wire prog_cmd = cmd_ok & (req.wdata == PNP_PROGRAM_COMMAND);
  wire verify_cmd = cmd_ok & (req.wdata == PNP_VERIFY_COMMAND);
  wire wake = wake_sync[1] & wake_sync[2] & in_initialize;
  wire [7:0] cur_word = settings[idx*8 +: 8];
  wire word_diff = (nvm[idx] != cur_word);
  wire last = (idx == PNP_IDX_LAST);
  wire [7:0] cmd_view = {verify_pass, 5'h00, comm_enabled, busy};
  wire [7:0] rd_view = (rd_addr == PNP_ADDR_PIN_CONTROL) ? pin_control :
    (rd_addr == PNP_ADDR_NVM_CMD) ? cmd_view : 8'h00;
  assign busy = (state != PNP_IDLE);
  assign rails_on = ~in_initialize;

  // ---------------------------------
  // sequencer
  // ---------------------------------
  always_comb
  begin
    case (state)
      PNP_IDLE:
        if (prog_cmd)
          next_state = PNP_PROG;
        else if (verify_cmd)
          next_state = PNP_VERIFY;
        else
          next_state = PNP_IDLE;
      PNP_PROG: next_state = last ? PNP_IDLE : PNP_PROG;
      PNP_VERIFY: next_state = last ? PNP_IDLE : PNP_VERIFY;
      default: next_state = PNP_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state <= PNP_IDLE;
      idx <= '0;
      mismatch <= 1'b0;
      verify_pass <= 1'b0;
    end
    else
    begin
      state <= next_state;
      idx <= (state == PNP_IDLE) ? '0 : idx + 1'b1;
      if (verify_cmd)
        mismatch <= 1'b0;
      else if (state == PNP_VERIFY)
        mismatch <= mismatch | word_diff;
      if (state == PNP_VERIFY && last)
        verify_pass <= ~(mismatch | word_diff);
    end
  end

  // memory write, one word per cycle
  always_ff @(posedge clk_sys)
  begin
    if (state == PNP_PROG)
      nvm[idx] <= cur_word;
  end

  // ---------------------------------
  // power state and registers
  // ---------------------------------
  // wake pin through three flops
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      wake_sync <= 3'b000;
    else
      wake_sync <= {wake_sync[1:0], wake_pin};
  end

  // pin control byte, stored as written
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      pin_control <= PNP_PIN_CONTROL_RESET;
    else if (hit_pin)
      pin_control <= req.wdata;
  end

  // initialize entry and exit
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      in_initialize <= 1'b0;
    else if (off_req)
      in_initialize <= 1'b1;
    else if (wake)
      in_initialize <= 1'b0;
  end

  // communication enable inside initialize
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      comm_enabled <= 1'b0;
    else if (off_req)
      comm_enabled <= 1'b0;
    else if (comm_cmd)
      comm_enabled <= 1'b1;
    else if (wake)
      comm_enabled <= 1'b0;
  end

  // register read port, one cycle latency
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rd_data <= 8'h00;
    else
      rd_data <= rd_view;
  end

  // memory read port, one cycle latency
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      nvm_rd_data <= 8'h00;
    else
      nvm_rd_data <= nvm[nvm_rd_idx];
  end

  // ---------------------------------
  // checks
  // ---------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_off_enters_init: assert property (off_req |=> in_initialize && !rails_on && !comm_enabled)
    else $error("off request did not enter initialize");
  a_comm_enable_set: assert property (comm_cmd && !off_req |=> comm_enabled)
    else $error("enable command did not enable communication");
  a_program_walk: assert property (prog_cmd |=> state == PNP_PROG ##15 state == PNP_PROG
    ##1 state == PNP_IDLE)
    else $error("program pass not sixteen cycles");
  a_verify_walk: assert property (verify_cmd |=> busy [*8] ##1 busy [*8] ##1 !busy)
    else $error("verify pass length wrong");
  a_locked_refuses: assert property (in_initialize && !comm_enabled && hit_cmd && !busy
    |=> !busy)
    else $error("command taken before communication enable");
  a_prog_stores_word: assert property (state == PNP_PROG |=>
    nvm[$past(idx)] == $past(cur_word))
    else $error("program pass did not store the settings word");
  a_result_holds: assert property (!(state == PNP_VERIFY && last) |=>
    $stable(verify_pass))
    else $error("verify result changed outside a verify pass");
  a_wake_leaves_init: assert property (wake && !off_req |=>
    !in_initialize && !comm_enabled)
    else $error("wake did not leave initialize");
  a_result_read: assert property (rd_addr == PNP_ADDR_NVM_CMD |=>
    rd_data[PNP_VERIFY_RESULT_BIT] == $past(verify_pass))
    else $error("verify result not visible in bit 7");

  c_program: cover property (prog_cmd ##17 !busy);
  c_verify_pass: cover property (verify_cmd ##17 verify_pass);
  c_verify_fail: cover property (verify_cmd ##17 !verify_pass);
  c_locked_refused: cover property (in_initialize && !comm_enabled && hit_cmd);
  c_init_then_enable: cover property (off_req ##[1:20] comm_cmd);
endmodule // pnp_nvm_seq
`default_nettype wire

// ==== pnp_host_model.sv ====
/* pnp_host_model: host register writer and reader.
   assumes: called from the bench, on clk_sys. */
`timescale 1ns/1ns
`default_nettype none
module pnp_host_model
  import pnp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [7:0] rd_data,
  output var pnp_req_t req,
  output logic [7:0] rd_addr
);
  initial
  begin
    req = '0;
    rd_addr = 8'h00;
  end
  // write held up to its taking edge; read sampled after rd_data registers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    rd_addr <= a;
    repeat (2) @(posedge clk_sys);
    #1 d = rd_data;
  endtask
endmodule // pnp_host_model
`default_nettype wire

// ==== test_pnp_nvm_seq.sv ====
/* test_pnp_nvm_seq: register level tests of program and verify.
   assumes: pnp_host_model as the register host. */
`timescale 1ns/1ns
`default_nettype none
module test_pnp_nvm_seq;
  import pnp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic wake_pin = 1'b0;
  logic [3:0] nvm_rd_idx = 4'h0;
  logic [127:0] settings = 128'hf0e1d2c3b4a5968778695a4b3c2d1e0f;
  logic [7:0] rd_addr, rd_data, nvm_rd_data, v;
  logic rails_on, in_initialize, comm_enabled, busy;
  pnp_req_t req;
  int fail_count = 0;
  int checks = 0;
  int n;
  always #10 clk_sys = ~clk_sys;
  pnp_host_model i_pnp_host_model (.clk_sys(clk_sys), .rd_data(rd_data), .req(req),
    .rd_addr(rd_addr));
  pnp_nvm_seq i_pnp_nvm_seq (.clk_sys(clk_sys), .rst(rst), .req(req), .rd_addr(rd_addr),
    .rd_data(rd_data), .settings(settings), .wake_pin(wake_pin), .rails_on(rails_on),
    .in_initialize(in_initialize), .comm_enabled(comm_enabled), .busy(busy),
    .nvm_rd_idx(nvm_rd_idx), .nvm_rd_data(nvm_rd_data));
  // ---------------------------------
  // compare, verdict, busy count
  // ---------------------------------
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic run_cmd(logic [7:0] c);
    i_pnp_host_model.wr(PNP_ADDR_NVM_CMD, c);
    n = 0;
    repeat (30)
    begin
      #1 n += busy;
      @(posedge clk_sys);
    end
  endtask
  initial
  begin
    #200000;
    fail_count++;
    results();
  end
  // ---------------------------------
  // tests
  // ---------------------------------
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    i_pnp_host_model.rd(PNP_ADDR_NVM_CMD, v);
    chk("cmd_reset", v, 8'h00);
    i_pnp_host_model.wr(PNP_ADDR_PIN_CONTROL, PNP_OFF_REQUEST);
    #1 chk("init", {in_initialize, rails_on}, 8'h02);
    run_cmd(PNP_PROGRAM_COMMAND);
    chk("locked", n[7:0], 8'h00);
    i_pnp_host_model.wr(PNP_ADDR_NVM_CMD, PNP_COMM_ENABLE_COMMAND);
    i_pnp_host_model.rd(PNP_ADDR_NVM_CMD, v);
    chk("comm", v, 8'h02);
    run_cmd(PNP_PROGRAM_COMMAND);
    chk("prog_busy", n[7:0], 8'h10);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk_sys);
      nvm_rd_idx <= i[3:0];
      repeat (2) @(posedge clk_sys);
      #1 chk("nvm_word", nvm_rd_data, settings[8*i+:8]);
    end
    run_cmd(PNP_VERIFY_COMMAND);
    chk("ver_busy", n[7:0], 8'h10);
    i_pnp_host_model.rd(PNP_ADDR_NVM_CMD, v);
    chk("pass", v, 8'h82);
    settings[15:8] <= 8'h00;
    run_cmd(PNP_VERIFY_COMMAND);
    i_pnp_host_model.rd(PNP_ADDR_NVM_CMD, v);
    chk("fail", v, 8'h02);
    wake_pin <= 1'b1;
    repeat (6) @(posedge clk_sys);
    #1 chk("wake", {in_initialize, comm_enabled, rails_on}, 8'h01);
    i_pnp_host_model.wr(PNP_ADDR_PIN_CONTROL, 8'h5a);
    i_pnp_host_model.rd(PNP_ADDR_PIN_CONTROL, v);
    chk("pin_store", v, 8'h5a);
    chk("pin_no_off", {7'h00, in_initialize}, 8'h00);
    results();
  end
endmodule // test_pnp_nvm_seq
`default_nettype wire
